// ===== sideband_init_pkg.sv
/*
  Constants shared by the sideband channel state logic: channel count, identifier
  layout, command opcodes and the response and reason codes.
  Assumes the command decoder upstream hands over header fields already parsed.
*/
package sideband_init_pkg;

  localparam int NUM_CHANNELS = 4;

  // Channel identifier layout: package id in [7:5], internal channel id in [4:0]
  localparam int CHID_W = 8;
  localparam int PKGID_MSB = 7;
  localparam int PKGID_LSB = 5;
  localparam int ICH_MSB = 4;
  localparam int ICH_LSB = 0;
  localparam logic [4:0] ICH_WHOLE_PKG = 5'h1f;

  // Command opcodes seen by this block
  localparam logic [7:0] OP_CLEAR_INIT = 8'h00;
  localparam logic [7:0] OP_SELECT_PKG = 8'h01;
  localparam logic [7:0] OP_DESELECT_PKG = 8'h02;
  localparam logic [7:0] OP_ENABLE_CHAN = 8'h03;
  localparam logic [7:0] OP_DISABLE_CHAN = 8'h04;
  localparam logic [7:0] OP_RESET_CHAN = 8'h05;
  localparam logic [7:0] OP_ENABLE_NET_TX = 8'h06;
  localparam logic [7:0] OP_DISABLE_NET_TX = 8'h07;
  localparam logic [7:0] OP_SET_FILTERS = 8'h08;
  localparam logic [7:0] OP_SET_EVENTS = 8'h09;

  // Response and reason codes
  localparam logic [15:0] RSP_COMPLETED = 16'h0000;
  localparam logic [15:0] RSP_FAILED = 16'h0001;
  localparam logic [15:0] RSN_NONE = 16'h0000;
  localparam logic [15:0] RSN_INIT_REQUIRED = 16'h0001;

  // Filter enable bit positions in the set-filters data byte
  localparam int FILT_MAC = 0;
  localparam int FILT_VLAN = 1;
  localparam int FILT_MCAST = 2;
  localparam int FILT_BCAST = 3;
  localparam int FILT_W = 4;

  // Reset values
  localparam logic FILT_RST = 1'b0;
  localparam logic [3:0] FILT_ALL_OFF = 4'h0;
  localparam logic [7:0] EVENTS_OFF = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [2:0] PKGID_RST = 3'h0;
  localparam logic HW_ARB_POWER_UP = 1'b1;

  // Cycles after reset release before the strapped package id is taken
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage : sideband_init_pkg

// ===== chan_if.sv
/*
  Carrier between the package-level logic and one channel's state holder.
  Assumes one instance per channel, all on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface chan_if;
  logic ce;
  logic go;
  logic [7:0] op;
  logic [7:0] data;
  logic [7:0] iid;
  logic async_rst;
  logic pt_rx;
  logic init;
  logic enabled;
  logic net_tx;
  logic [7:0] events;
  logic [3:0] filt;
  logic [15:0] cmd_cnt;
  logic [15:0] pt_cnt;
  logic iid_valid;
  logic [7:0] last_iid;

  modport pkg_side (
    output ce, go, op, data, iid, async_rst, pt_rx,
    input init, enabled, net_tx, events, filt, cmd_cnt, pt_cnt, iid_valid, last_iid
  );
  modport chan_side (
    input ce, go, op, data, iid, async_rst, pt_rx,
    output init, enabled, net_tx, events, filt, cmd_cnt, pt_cnt, iid_valid, last_iid
  );
endinterface : chan_if

`default_nettype wire

// ===== chan_state.sv
/*
  State of one channel: initial state flag, enable, network tx, filters,
  event enables, statistics and remembered instance id.
  Assumes the package side only raises go for commands it lets through.
*/
`timescale 1ns/100ps
`default_nettype none

module chan_state
  import sideband_init_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  chan_if.chan_side cif
);

  logic init_ff, enabled_ff, net_tx_ff, iid_valid_ff;
  logic [7:0] events_ff, last_iid_ff;
  logic [3:0] filt_ff;
  logic [15:0] cmd_cnt_ff, pt_cnt_ff;

  // Entry into the initial state: power up, asynchronous fault or reset command
  wire reset_cmd = cif.go && cif.op == OP_RESET_CHAN;
  wire enter_init = cif.async_rst || reset_cmd; // R15 R17
  wire clear_cmd = cif.go && cif.op == OP_CLEAR_INIT;
  wire pt_count = cif.pt_rx && net_tx_ff && !init_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Entry wins over any command in the same cycle.
  // Nothing here touches the network link; only sideband settings move. R12
  always_ff @(posedge clk) begin
    if (rst) begin
      init_ff <= 1'b1; // R15
      enabled_ff <= 1'b0;
      net_tx_ff <= 1'b0;
      events_ff <= EVENTS_OFF;
      filt_ff <= FILT_ALL_OFF;
      cmd_cnt_ff <= COUNT_ZERO;
      pt_cnt_ff <= COUNT_ZERO;
      iid_valid_ff <= 1'b0;
      last_iid_ff <= 8'h00;
    end else if (cif.ce) begin
      if (enter_init) begin
        init_ff <= 1'b1; // R2
        enabled_ff <= 1'b0; // R4
        filt_ff <= FILT_ALL_OFF; // R6 R7
        cmd_cnt_ff <= COUNT_ZERO; // R8
        pt_cnt_ff <= COUNT_ZERO; // R8
        net_tx_ff <= 1'b0; // R9
        iid_valid_ff <= 1'b0; // R10
        events_ff <= EVENTS_OFF; // R11
      end else begin
        if (pt_count)
          pt_cnt_ff <= pt_cnt_ff + 16'h0001;
        if (cif.go) begin
          cmd_cnt_ff <= cmd_cnt_ff + 16'h0001;
          iid_valid_ff <= 1'b1;
          last_iid_ff <= cif.iid;
          if (clear_cmd)
            init_ff <= 1'b0; // R2 R23
          case (cif.op)
            OP_ENABLE_CHAN: enabled_ff <= 1'b1;
            OP_DISABLE_CHAN: enabled_ff <= 1'b0;
            OP_ENABLE_NET_TX: net_tx_ff <= 1'b1;
            OP_DISABLE_NET_TX: net_tx_ff <= 1'b0;
            OP_SET_FILTERS: filt_ff <= cif.data[FILT_W-1:0];
            OP_SET_EVENTS: events_ff <= cif.data;
            default: ;
          endcase
        end
      end
    end
  end

  assign cif.init = init_ff;
  assign cif.enabled = enabled_ff;
  assign cif.net_tx = net_tx_ff;
  assign cif.events = events_ff;
  assign cif.filt = filt_ff;
  assign cif.cmd_cnt = cmd_cnt_ff;
  assign cif.pt_cnt = pt_cnt_ff;
  assign cif.iid_valid = iid_valid_ff;
  assign cif.last_iid = last_iid_ff;

endmodule : chan_state

`default_nettype wire

// ===== sideband_channel_init_state.sv
/*
  Package and channel operating-state logic of a sideband management interface:
  command acceptance, initial state entry and exit, defaults, transmit gating.
  Assumes commands arrive parsed, one per cmd_valid pulse, on clk; package id
  straps and the arbitration token come from pins.
*/
// Contract
// R1 - In package ready state, answer every command sent to the whole-package id.
// R2 - Channel leaves initial state only on Clear Initial State; controller must send it.
// R3 - In initial state, non-OEM commands except clear fail with initialization required.
// R4 - Entering initial state forces the channel disabled.
// R5 - Arbitration enable set on power up only; other entries keep it.
// R6 - Entry clears every MAC and VLAN filter enable.
// R7 - Entry also clears global multicast and broadcast filters.
// R8 - Entry resets all statistics counters and pass-through statistics to zero.
// R9 - Entry disables network transmit and pass-through forwarding.
// R10 - Entry forgets instance ids; next command is always new.
// R11 - Entry disables event notifications and clears their enables.
// R12 - Initial state entry or exit leaves network link state alone.
// R13 - Controller reapplies settings after an initialization-required rejection.
// R14 - With arbitration on, drive only when selected and holding the token.
// R15 - Power up, resets, faults and configuration loss enter initial state.
// R16 - A package-wide asynchronous reset may put all channels in initial state.
// R17 - Reset Channel command puts the addressed channel in initial state.
// R18 - Each channel has an integration-time configurable identifier used for addressing.
// R19 - Identifier is package id plus internal channel id; both are decoded.
// R20 - Internal id 0x1F means package command; others are channel commands.
// R21 - Disabled channel sends no unrequested packets, only responses.
// R22 - With arbitration off, a selected package may transmit anytime.
// R23 - After clear, channel executes normally with its entry defaults.
`timescale 1ns/100ps
`default_nettype none

module sideband_channel_init_state
  import sideband_init_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] pkg_id_pins,
  input wire logic token_pin,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_chan_id,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] cmd_iid,
  input wire logic cmd_oem,
  input wire logic pkg_async_rst,
  input wire logic [NUM_CHANNELS-1:0] chan_async_rst,
  input wire logic [NUM_CHANNELS-1:0] pt_rx,
  output logic rsp_valid,
  output logic [7:0] rsp_chan_id,
  output logic [15:0] rsp_code,
  output logic [15:0] rsp_reason,
  output logic rsp_retry,
  output logic pkg_ready,
  output logic pkg_selected,
  output logic hw_arb_en,
  output logic bus_drive_en,
  output logic [NUM_CHANNELS-1:0] chan_init,
  output logic [NUM_CHANNELS-1:0] chan_enabled,
  output logic [NUM_CHANNELS-1:0] chan_net_tx,
  output logic [NUM_CHANNELS-1:0] chan_unsol_ok,
  output logic [NUM_CHANNELS*8-1:0] chan_events,
  output logic [NUM_CHANNELS*4-1:0] chan_filters,
  output logic [NUM_CHANNELS*16-1:0] chan_cmd_count,
  output logic [NUM_CHANNELS*16-1:0] chan_pt_count
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] pkgid_s1_ff, pkgid_s2_ff;
  logic token_s1_ff, token_s2_ff;

  always_ff @(posedge clk) begin
    if (ce) begin
      pkgid_s1_ff <= pkg_id_pins;
      pkgid_s2_ff <= pkgid_s1_ff;
      token_s1_ff <= token_pin;
      token_s2_ff <= token_s1_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Package id capture and package ready
  // Straps are taken once after reset so the id cannot move under live traffic.

  logic [1:0] settle_ff;
  logic [2:0] pkg_id_ff;
  logic pkg_ready_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      settle_ff <= 2'h0;
      pkg_id_ff <= PKGID_RST;
      pkg_ready_ff <= 1'b0;
    end else if (ce) begin
      if (settle_ff != STRAP_SETTLE) begin
        settle_ff <= settle_ff + 2'h1;
      end else if (!pkg_ready_ff) begin
        pkg_id_ff <= pkgid_s2_ff; // R18
        pkg_ready_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire [2:0] cmd_pkg = cmd_chan_id[PKGID_MSB:PKGID_LSB];
  wire [4:0] cmd_ich = cmd_chan_id[ICH_MSB:ICH_LSB];
  wire pkg_hit = cmd_valid && pkg_ready_ff && cmd_pkg == pkg_id_ff; // R19
  wire whole_pkg = pkg_hit && cmd_ich == ICH_WHOLE_PKG; // R20
  wire chan_hit = pkg_hit && cmd_ich < 5'(NUM_CHANNELS); // R19 R20
  wire [1:0] ch_sel = cmd_ich[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel state holders

  logic [NUM_CHANNELS-1:0] init_v, en_v, ntx_v, retry_v, go_v;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
      chan_if cif();
      wire sel = chan_hit && ch_sel == 2'(gi);
      wire blocked = cif.init && !cmd_oem && cmd_op != OP_CLEAR_INIT; // R3
      wire retry = cif.iid_valid && cif.last_iid == cmd_iid; // R10
      assign cif.ce = ce;
      assign cif.go = sel && !blocked && !retry; // R2 R23
      assign cif.op = cmd_op;
      assign cif.data = cmd_data;
      assign cif.iid = cmd_iid;
      assign cif.async_rst = chan_async_rst[gi] || pkg_async_rst; // R15 R16
      assign cif.pt_rx = pt_rx[gi];
      assign init_v[gi] = cif.init;
      assign en_v[gi] = cif.enabled;
      assign ntx_v[gi] = cif.net_tx;
      assign retry_v[gi] = sel && !blocked && retry;
      assign go_v[gi] = sel && blocked;
      assign chan_events[gi*8 +: 8] = cif.events;
      assign chan_filters[gi*4 +: 4] = cif.filt;
      assign chan_cmd_count[gi*16 +: 16] = cif.cmd_cnt;
      assign chan_pt_count[gi*16 +: 16] = cif.pt_cnt;

      chan_state u_chan (
        .clk(clk),
        .rst(rst),
        .cif(cif)
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Package selection and arbitration enable

  logic selected_ff, hw_arb_ff;

  wire sel_cmd = whole_pkg && cmd_op == OP_SELECT_PKG;
  wire desel_cmd = whole_pkg && cmd_op == OP_DESELECT_PKG;

  always_ff @(posedge clk) begin
    if (rst) begin
      selected_ff <= 1'b0;
      hw_arb_ff <= HW_ARB_POWER_UP; // R5
    end else if (ce) begin
      if (sel_cmd) begin
        selected_ff <= 1'b1;
        hw_arb_ff <= cmd_data[0];
      end else if (desel_cmd) begin
        selected_ff <= 1'b0;
      end
    end
  end

  // Token only counts while arbitration is on; off, selection alone suffices.
  wire may_drive = selected_ff && (!hw_arb_ff || token_s2_ff); // R14 R22

  //////////////////////////////////////////////////////////////////////////////
  // Response generation
  // Invalid channel numbers and other packages get no answer at all.

  wire blocked_hit = |go_v;
  wire answer = whole_pkg || chan_hit; // R1
  wire [15:0] nxt_code = blocked_hit ? RSP_FAILED : RSP_COMPLETED; // R3
  wire [15:0] nxt_reason = blocked_hit ? RSN_INIT_REQUIRED : RSN_NONE; // R3

  logic rsp_valid_ff, rsp_retry_ff;
  logic [7:0] rsp_chan_ff;
  logic [15:0] rsp_code_ff, rsp_reason_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_retry_ff <= 1'b0;
      rsp_chan_ff <= 8'h00;
      rsp_code_ff <= RSP_COMPLETED;
      rsp_reason_ff <= RSN_NONE;
    end else if (ce) begin
      rsp_valid_ff <= answer;
      if (answer) begin
        rsp_chan_ff <= cmd_chan_id;
        rsp_code_ff <= nxt_code;
        rsp_reason_ff <= nxt_reason;
        rsp_retry_ff <= |retry_v;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered status outputs

  logic drive_ff;
  logic [NUM_CHANNELS-1:0] unsol_ff, init_ff, en_ff, ntx_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_ff <= 1'b0;
      unsol_ff <= '0;
      init_ff <= '1;
      en_ff <= '0;
      ntx_ff <= '0;
    end else if (ce) begin
      drive_ff <= may_drive; // R14
      unsol_ff <= en_v & ~init_v & {NUM_CHANNELS{may_drive}}; // R21
      init_ff <= init_v;
      en_ff <= en_v;
      ntx_ff <= ntx_v & ~init_v; // R9
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_chan_id = rsp_chan_ff;
  assign rsp_code = rsp_code_ff;
  assign rsp_reason = rsp_reason_ff;
  assign rsp_retry = rsp_retry_ff;
  assign pkg_ready = pkg_ready_ff;
  assign pkg_selected = selected_ff;
  assign hw_arb_en = hw_arb_ff;
  assign bus_drive_en = drive_ff;
  assign chan_init = init_ff;
  assign chan_enabled = en_ff;
  assign chan_net_tx = ntx_ff;
  assign chan_unsol_ok = unsol_ff;

endmodule : sideband_channel_init_state

`default_nettype wire

// ===== sbci_checker.sv
/*
  Port assertions for the sideband channel state block.
  Assumes one clock, synchronous active-high reset, bound from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module sbci_checker
  import sideband_init_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic token_pin,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_chan_id,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_chan_id,
  input wire logic [15:0] rsp_code,
  input wire logic [15:0] rsp_reason,
  input wire logic pkg_ready,
  input wire logic pkg_selected,
  input wire logic hw_arb_en,
  input wire logic bus_drive_en,
  input wire logic [NUM_CHANNELS-1:0] chan_init,
  input wire logic [NUM_CHANNELS-1:0] chan_enabled,
  input wire logic [NUM_CHANNELS-1:0] chan_net_tx,
  input wire logic [NUM_CHANNELS-1:0] chan_unsol_ok,
  input wire logic [NUM_CHANNELS*8-1:0] chan_events,
  input wire logic [NUM_CHANNELS*4-1:0] chan_filters,
  input wire logic [NUM_CHANNELS*16-1:0] chan_pt_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  rsp_cause_a: assert property (rsp_valid |-> $past(cmd_valid && ce && pkg_ready))
    else $error("response without a taken command");
  unready_quiet_a: assert property (cmd_valid && !pkg_ready |=> !rsp_valid)
    else $error("response while package not ready");
  chan_echo_a: assert property (rsp_valid |-> rsp_chan_id == $past(cmd_chan_id))
    else $error("response channel id mismatch");
  fail_reason_a: assert property (rsp_valid && rsp_code == RSP_FAILED |->
    rsp_reason == RSN_INIT_REQUIRED) else $error("failed response with wrong reason");
  init_quiet_a: assert property ((chan_init & (chan_enabled | chan_net_tx | chan_unsol_ok))
    == {NUM_CHANNELS{1'b0}}) else $error("channel in initial state still active");
  entry_clear_a: assert property ($rose(chan_init[0]) |-> chan_filters[3:0] == FILT_ALL_OFF
    && chan_events[7:0] == EVENTS_OFF && chan_pt_count[15:0] == COUNT_ZERO)
    else $error("defaults not applied on entry");
  drive_sel_a: assert property (bus_drive_en |-> $past(pkg_selected))
    else $error("bus driven while deselected");
  drive_token_a: assert property (bus_drive_en && $past(hw_arb_en) |-> $past(token_pin, 3))
    else $error("bus driven without token");
  arb_keep_a: assert property ($changed(hw_arb_en) |-> rsp_valid && $past(cmd_valid))
    else $error("arbitration enable changed without command");
  cover property (rsp_valid && rsp_code == RSP_FAILED);
  cover property ($rose(bus_drive_en));
  cover property ($rose(chan_init[1]));
endmodule : sbci_checker
`default_nettype wire

// ===== mc_model.sv
/*
  Management controller model: issues parsed commands one at a time.
  Assumes a single calling process and the block's clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mc_model
  import sideband_init_pkg::*;
(
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_chan_id,
  output logic [7:0] cmd_op,
  output logic [7:0] cmd_data,
  output logic [7:0] cmd_iid,
  output logic cmd_oem
);
  initial begin
    cmd_valid = 1'b0;
    {cmd_chan_id, cmd_op, cmd_data, cmd_iid, cmd_oem} = '0;
  end
  task automatic send(input logic [7:0] id, op, dt, iid, input logic oem);
    @(posedge clk);
    #1;
    {cmd_valid, cmd_chan_id, cmd_op, cmd_data, cmd_iid, cmd_oem} = {1'b1, id, op, dt, iid, oem};
    @(posedge clk);
    #1;
    // Released fields invert so a stale command never looks valid
    {cmd_valid, cmd_chan_id, cmd_op, cmd_data, cmd_iid} = {1'b0, ~id, ~op, ~dt, ~iid};
  endtask : send
  // After an init-required rejection settings are assumed lost: clear first
  task automatic recover(input logic [7:0] id, iid);
    send(id, OP_CLEAR_INIT, 8'h00, iid, 1'b0);
  endtask : recover
endmodule : mc_model
`default_nettype wire

// ===== sideband_channel_init_state_tb_top.sv
/*
  Self-checking bench for the sideband channel state block.
  Assumes the controller model drives commands; straps fixed at one id.
*/
`timescale 1ns/100ps
`default_nettype none
module sideband_channel_init_state_tb_top;
  import sideband_init_pkg::*;
  localparam logic [2:0] PKG = 3'h2;
  logic clk, rst, ce, token_pin, pkg_async_rst, cmd_valid, cmd_oem, rsp_valid, rsp_retry;
  logic pkg_ready, pkg_selected, hw_arb_en, bus_drive_en;
  logic [2:0] pkg_id_pins;
  logic [3:0] chan_async_rst, pt_rx, chan_init, chan_enabled, chan_net_tx, chan_unsol_ok;
  logic [7:0] cmd_chan_id, cmd_op, cmd_data, cmd_iid, rsp_chan_id, r, d;
  logic [15:0] rsp_code, rsp_reason;
  logic [31:0] chan_events;
  logic [15:0] chan_filters;
  logic [63:0] chan_cmd_count, chan_pt_count;
  logic [40:0] exp_q[$];
  int n_errors = 0;
  int check_count = 0;
  integer seed = 90678;
  mc_model m (.clk, .cmd_valid, .cmd_chan_id, .cmd_op, .cmd_data, .cmd_iid, .cmd_oem);
  sideband_channel_init_state uut (.clk, .rst, .ce, .pkg_id_pins, .token_pin, .cmd_valid,
    .cmd_chan_id, .cmd_op, .cmd_data, .cmd_iid, .cmd_oem, .pkg_async_rst, .chan_async_rst,
    .pt_rx, .rsp_valid, .rsp_chan_id, .rsp_code, .rsp_reason, .rsp_retry, .pkg_ready,
    .pkg_selected, .hw_arb_en, .bus_drive_en, .chan_init, .chan_enabled, .chan_net_tx,
    .chan_unsol_ok, .chan_events, .chan_filters, .chan_cmd_count, .chan_pt_count);
  task automatic chk(input string nm, input logic [63:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // k: 0 no answer, 1 completed, 2 init required, 3 retry
  task automatic cmd(input logic [4:0] ich, input logic [7:0] op, dt, id,
      input logic oem, input logic [1:0] k);
    if (k == 2'h1) exp_q.push_back({PKG, ich, RSP_COMPLETED, RSN_NONE, 1'b0});
    if (k == 2'h2) exp_q.push_back({PKG, ich, RSP_FAILED, RSN_INIT_REQUIRED, 1'b0});
    if (k == 2'h3) exp_q.push_back({PKG, ich, RSP_COMPLETED, RSN_NONE, 1'b1});
    m.send({PKG, ich}, op, dt, id, oem);
  endtask : cmd
  task automatic st(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : st
  task automatic close_out;
    chk("pending responses", 64'h0, 64'(exp_q.size()));
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected response", 64'h0, 64'h1);
      else chk("response", 64'(exp_q.pop_front()),
        64'({rsp_chan_id, rsp_code, rsp_reason, rsp_retry}));
    end
  end
  initial begin
    #100us;
    n_errors++;
    close_out();
  end
  initial begin
    {rst, ce, token_pin, pkg_async_rst, chan_async_rst, pt_rx, pkg_id_pins} = {2'h3, 10'h0, PKG};
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    cmd(5'h00, OP_CLEAR_INIT, 8'h00, 8'h00, 1'b0, 2'h0);
    for (int i = 0; i < 20 && pkg_ready !== 1'b1; i++) @(posedge clk);
    st(1);
    chk("init after power up", 64'hf, 64'(chan_init));
    chk("arb after power up", 64'h1, 64'(hw_arb_en));
    r = 8'($random(seed));
    // Low bit forced so filters and events always differ from their cleared value
    d = 8'($random(seed)) | 8'h01;
    m.send({3'h5, 5'h00}, OP_CLEAR_INIT, 8'h00, r, 1'b0);
    cmd(5'h04, OP_CLEAR_INIT, 8'h00, r, 1'b0, 2'h0);
    cmd(5'h00, OP_SET_EVENTS, 8'hff, r, 1'b0, 2'h2);
    cmd(5'h00, 8'h80, 8'h00, r + 8'h1, 1'b1, 2'h1);
    exp_q.push_back({PKG, 5'h00, RSP_COMPLETED, RSN_NONE, 1'b0});
    m.recover({PKG, 5'h00}, r + 8'h2);
    cmd(5'h00, OP_CLEAR_INIT, 8'h00, r + 8'h2, 1'b0, 2'h3);
    cmd(5'h00, OP_SET_FILTERS, d, r + 8'h3, 1'b0, 2'h1);
    cmd(5'h00, OP_ENABLE_NET_TX, 8'h00, r + 8'h4, 1'b0, 2'h1);
    st(3);
    chk("filters", 64'(d[3:0]), 64'(chan_filters[3:0]));
    pt_rx = 4'h1;
    st(1);
    pt_rx = 4'h0;
    st(3);
    chk("pass-through count", 64'h1, 64'(chan_pt_count[15:0]));
    // Clock enable low: neither the pass-through pulse nor the command may land
    ce = 1'b0;
    pt_rx = 4'h1;
    cmd(5'h00, OP_DISABLE_NET_TX, 8'h00, r + 8'h9, 1'b0, 2'h0);
    pt_rx = 4'h0;
    ce = 1'b1;
    st(2);
    chk("frozen count", 64'h1, 64'(chan_pt_count[15:0]));
    chk("net tx", 64'h1, 64'(chan_net_tx));
    cmd(5'h00, OP_SET_EVENTS, d, r + 8'h5, 1'b0, 2'h1);
    cmd(5'h00, OP_ENABLE_CHAN, 8'h00, r + 8'h6, 1'b0, 2'h1);
    st(2);
    chk("events", 64'(d), 64'(chan_events[7:0]));
    chk("enabled", 64'h1, 64'(chan_enabled));
    chk("command count", 64'h6, 64'(chan_cmd_count[15:0]));
    cmd(5'h00, OP_RESET_CHAN, 8'h00, r + 8'h7, 1'b0, 2'h1);
    st(3);
    chk("init after reset", 64'h1, 64'(chan_init[0]));
    chk("defaults", 64'h0, 64'({chan_filters[3:0], chan_events[7:0], chan_pt_count[15:0],
      chan_cmd_count[15:0], chan_enabled[0], chan_net_tx[0]}));
    cmd(5'h00, OP_CLEAR_INIT, 8'h00, r + 8'h7, 1'b0, 2'h1);
    for (int i = 1; i < 4; i++) cmd(5'(i), OP_CLEAR_INIT, 8'h00, r, 1'b0, 2'h1);
    chan_async_rst = 4'h2;
    st(1);
    chan_async_rst = 4'h0;
    st(3);
    chk("channel async entry", 64'h2, 64'(chan_init));
    cmd(5'h1f, OP_SELECT_PKG, 8'h01, r, 1'b0, 2'h1);
    st(4);
    chk("drive without token", 64'h0, 64'(bus_drive_en));
    chk("selected", 64'h1, 64'(pkg_selected));
    token_pin = 1'b1;
    st(4);
    chk("drive with token", 64'h1, 64'(bus_drive_en));
    cmd(5'h00, OP_ENABLE_CHAN, 8'h00, r + 8'h8, 1'b0, 2'h1);
    st(3);
    chk("unsolicited", 64'h1, 64'(chan_unsol_ok));
    cmd(5'h1f, OP_SELECT_PKG, 8'h00, r + 8'h1, 1'b0, 2'h1);
    token_pin = 1'b0;
    st(4);
    chk("drive arb off", 64'h1, 64'(bus_drive_en));
    pkg_async_rst = 1'b1;
    st(1);
    pkg_async_rst = 1'b0;
    st(3);
    chk("package entry", 64'hf, 64'(chan_init));
    chk("arb kept", 64'h0, 64'(hw_arb_en));
    chk("unsolicited after entry", 64'h0, 64'(chan_unsol_ok));
    for (int i = 1; i < 10; i++) cmd(5'h02, 8'(i), d, r + 8'(i), 1'b0, 2'h2);
    cmd(5'h1f, OP_DESELECT_PKG, 8'h00, r, 1'b0, 2'h1);
    st(4);
    chk("drive deselected", 64'h0, 64'(bus_drive_en));
    // Second power up in mid-run: arbitration returns to enabled, ready re-settles
    rst = 1'b1;
    st(2);
    rst = 1'b0;
    st(6);
    chk("ready after reset", 64'h1, 64'(pkg_ready));
    chk("arb after reset", 64'h1, 64'(hw_arb_en));
    chk("init after reset all", 64'hf, 64'(chan_init));
    close_out();
  end
endmodule : sideband_channel_init_state_tb_top
bind sideband_channel_init_state sbci_checker chk_i (.clk, .rst, .ce, .token_pin, .cmd_valid,
  .cmd_chan_id, .rsp_valid, .rsp_chan_id, .rsp_code, .rsp_reason, .pkg_ready, .pkg_selected,
  .hw_arb_en, .bus_drive_en, .chan_init, .chan_enabled, .chan_net_tx, .chan_unsol_ok,
  .chan_events, .chan_filters, .chan_pt_count);
`default_nettype wire
